// ===== dsr_map.svh
// register indices, field positions, reset values and fixed codes of the shared register bank
// included by the bank; definitions only
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH

// register indices; the byte address on apb is four times the index
`define DSR_IDX_IND_CTL    8'hb0
`define DSR_IDX_IND_OFF    8'hb1
`define DSR_IDX_IND_DATA   8'hb2
`define DSR_IDX_BIST       8'hb3
`define DSR_IDX_RSV_B4     8'hb4
`define DSR_IDX_RSV_B5     8'hb5
`define DSR_IDX_RSV_B6     8'hb6
`define DSR_IDX_RSV_B7     8'hb7
`define DSR_IDX_STRAP_STS  8'hb8
`define DSR_IDX_LINK_ERR   8'hb9
`define DSR_IDX_LOCK_STS   8'hc0

// reset values
`define DSR_RST_IND_SEL    4'h7
`define DSR_RST_IND_OFF    8'h3a
`define DSR_RST_BIST_CFG   1'h1
`define DSR_RST_RSV_B4     8'h25
`define DSR_RST_RSV_B5     8'h00
`define DSR_RST_RSV_B6     8'h18
`define DSR_RST_RSV_B7     8'h00
`define DSR_RST_ERR_MASK   1'h1
`define DSR_RST_ERR_EN     1'h1
`define DSR_RST_ERR_LIMIT  4'h3

// field positions
`define DSR_CTL_SEL_LSB    2
`define DSR_CTL_AUTOINC    1
`define DSR_CTL_PREFETCH   0
`define DSR_BIST_MODE_LSB  6
`define DSR_BIST_CFG       3
`define DSR_BIST_CLK_LSB   1
`define DSR_BIST_EN        0
`define DSR_STS_INDEX_STRAP_DONE   7
`define DSR_STS_IDX_LSB    4
`define DSR_STS_CFG_DONE   3
`define DSR_STS_CFG_LSB    0
`define DSR_ERR_MASK_BIT   5
`define DSR_ERR_EN_BIT     4
`define DSR_ERR_LIMIT_LSB  0

// remote serializer clock source register
`define DSR_REMOTE_CLK_OFF 8'h14

// strap capture: cycles for the three-stage synchroniser to fill
`define DSR_STRAP_FILL     2'h3

`endif

// ===== dsr_pkg.sv
// types shared by the shared register bank and its surroundings
// constants live in dsr_map.svh
package dsr_pkg;

	typedef enum logic [2:0] {
		DSR_ST_IDLE  = 3'b001,
		DSR_ST_FETCH = 3'b010,
		DSR_ST_DONE  = 3'b100
	} dsr_state_e;

	typedef enum logic [1:0] {
		DSR_PAT_NONE = 2'b00,
		DSR_PAT_ALT  = 2'b01,
		DSR_PAT_DATA = 2'b10
	} dsr_pattern_e;

	// request towards the indirect sub-blocks
	typedef struct packed {
		logic [3:0] target_sel;
		logic [7:0] offset;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dsr_ind_req_s;

	// write towards the remote serializer
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [1:0] data;
	} dsr_remote_s;

	// forward-link check results, pixel clock domain
	typedef struct packed {
		logic embedded_clock_bit_a;
		logic embedded_clock_bit_b;
		logic parity;
		logic framing_check_bit;
	} dsr_link_err_s;

	// state on pclk
	typedef struct packed {
		dsr_state_e   st;
		logic [7:0]   prdata;
		logic         pready;
		logic         pslverr;
		logic [3:0]   sel;
		logic         autoinc;
		logic         prefetch;
		logic [7:0]   offset;
		logic [7:0]   wdata;
		logic         ind_wr;
		logic         ind_rd;
		logic [1:0]   bist_mode;
		logic         bist_cfg;
		logic [1:0]   bist_clk;
		logic         bist_en;
		logic         bist_active;
		dsr_pattern_e pattern;
		dsr_remote_s  remote;
		logic [5:0]   strap_s1;
		logic [5:0]   strap_s2;
		logic [5:0]   strap_s3;
		logic [1:0]   fill;
		logic         strap_done;
		logic [2:0]   idx_val;
		logic [2:0]   cfg_val;
		logic         err_mask;
		logic         err_en;
		logic [3:0]   err_limit;
		logic [2:0]   lock_sync;
	} dsr_regs_s;

	// state on the recovered pixel clock
	typedef struct packed {
		logic [5:0] cfg_s1;
		logic [5:0] cfg_s2;
		logic [5:0] cfg_s3;
		logic [5:0] cfg_use;
		logic [3:0] count;
		logic       lock;
	} dsr_pix_s;

endpackage

// ===== dsr_shared_regs.sv
// shared control and status register bank of the deserializer hub: indirect access window,
// self-test control, strap decode status and forward-link lock monitor
// assumes an apb master on pclk, a recovered pixel clock for the link monitor and
// sub-blocks that answer an indirect read strobe within the strobe cycle
// Notes on behaviour
// R01: eight-bit indirect offset register, resets 0x3a
// R02: data write forwards byte to selected sub-block
// R03: data read returns sub-block contents, not copy
// R04: four-bit target select picks indirect sub-block
// R05: auto-increment bumps offset after each access
// R06: prefetch strobes read on offset write, auto-increment reads
// R07: output pattern field decodes none, alternate, data
// R08: config bit resets one; zero enables control
// R09: enabling sends clock choice to remote 0x14
// R10: bit zero enables self-test, resets disabled
// R11: index done flag set once latched
// R12: bits 6:4 report strapped index decode
// R13: config done flag set once latched
// R14: bits 2:0 report strapped config decode
// R15: mask bit ignores errors in filter wait
// R16: bit four enables error counter, resets on
// R17: counter drops lock reaching threshold, resets 3
// R18: counter disabled drops lock on first error
// R19: checks both clock bits, parity, framing bit
// R20: error counter runs on recovered pixel clock
// R21: strap decodes captured once, held until reset
`timescale 1ns/1ps
`include "dsr_map.svh"

module dsr_shared_regs (
	input  wire logic                  pclk,            // register clock, 40 mhz
	input  wire logic                  presetn,         // async reset, active low
	input  wire logic                  psel,            // apb select
	input  wire logic                  penable,         // apb access phase
	input  wire logic                  pwrite,          // apb direction
	input  wire logic [9:0]            paddr,           // apb byte address
	input  wire logic [31:0]           pwdata,          // apb write data
	output logic      [31:0]           prdata,          // apb read data
	output logic                       pready,          // apb ready
	output logic                       pslverr,         // apb error, unmapped or misaligned address
	output dsr_pkg::dsr_ind_req_s      ind_req,         // indirect request to sub-blocks
	input  wire logic [7:0]            ind_rdata,       // sub-block read data
	output dsr_pkg::dsr_remote_s       remote_cfg,      // write to remote serializer
	output logic                       bist_active,     // self-test running
	output dsr_pkg::dsr_pattern_e      bist_pattern,    // decoded output pattern
	input  wire logic [2:0]            index_strap_pin, // index strap level
	input  wire logic [2:0]            cfg_strap_pin,   // config strap level
	input  wire logic                  pix_clk,         // recovered pixel clock
	input  wire dsr_pkg::dsr_link_err_s link_err,       // forward-link checks, pix domain
	input  wire logic                  filter_wait,     // adaptive filter wait, pix domain
	input  wire logic                  lock_acquired,   // receiver locked pulse, pix domain
	output logic                       link_lock        // receiver lock, pix domain
);
	import dsr_pkg::*;

	dsr_regs_s q;
	dsr_regs_s d;
	dsr_pix_s  pq;
	dsr_pix_s  pd;
	logic [1:0] pix_rst_q;

	// bus decode
	logic       in_map;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic       acc;
	logic       done_edge;
	logic [7:0] rd_local;

	assign idx       = paddr[9:2];
	assign wbyte     = pwdata[7:0];
	assign acc       = psel && penable;
	assign done_edge = acc && (q.st == DSR_ST_DONE);

	// local read mux and address check
	always_comb begin
		in_map   = (paddr[1:0] == 2'h0);
		rd_local = 8'h00;
		case (idx)
			`DSR_IDX_IND_CTL:   rd_local = {2'h0, q.sel, q.autoinc, q.prefetch};
			`DSR_IDX_IND_OFF:   rd_local = q.offset; // R01
			`DSR_IDX_IND_DATA:  rd_local = 8'h00;
			`DSR_IDX_BIST:      rd_local = {q.bist_mode, 2'h0, q.bist_cfg, q.bist_clk, q.bist_en};
			`DSR_IDX_RSV_B4:    rd_local = `DSR_RST_RSV_B4;
			`DSR_IDX_RSV_B5:    rd_local = `DSR_RST_RSV_B5;
			`DSR_IDX_RSV_B6:    rd_local = `DSR_RST_RSV_B6;
			`DSR_IDX_RSV_B7:    rd_local = `DSR_RST_RSV_B7;
			`DSR_IDX_STRAP_STS: rd_local = {q.strap_done, q.idx_val, q.strap_done, q.cfg_val}; // R11 R13
			`DSR_IDX_LINK_ERR:  rd_local = {2'h0, q.err_mask, q.err_en, q.err_limit};
			`DSR_IDX_LOCK_STS:  rd_local = {7'h00, q.lock_sync[2]};
			default:            in_map   = 1'b0;
		endcase
	end

	// next state on pclk
	always_comb begin
		d        = q;
		d.ind_wr = 1'b0;
		d.ind_rd = 1'b0;
		d.remote.wr = 1'b0;

		// apb handshake: idle -> (fetch) -> done; pready stands one cycle in done
		unique case (q.st)
			DSR_ST_IDLE: begin
				if (acc) begin
					if (in_map && !pwrite && idx == `DSR_IDX_IND_DATA) begin
						d.ind_rd = 1'b1; // R03
						d.st     = DSR_ST_FETCH;
					end else begin
						d.prdata  = pwrite ? 8'h00 : rd_local;
						d.pslverr = !in_map;
						d.pready  = 1'b1;
						d.st      = DSR_ST_DONE;
					end
				end
			end
			DSR_ST_FETCH: begin
				// sub-block answers while the strobe stands
				d.prdata  = ind_rdata; // R03
				d.pslverr = 1'b0;
				d.pready  = 1'b1;
				d.st      = DSR_ST_DONE;
			end
			DSR_ST_DONE: begin
				d.pready  = 1'b0;
				d.pslverr = 1'b0;
				d.st      = DSR_ST_IDLE;
			end
		endcase

		// writes and access side effects take place on the completing edge only
		if (done_edge && in_map) begin
			if (pwrite) begin
				case (idx)
					`DSR_IDX_IND_CTL: begin
						d.sel      = wbyte[`DSR_CTL_SEL_LSB +: 4]; // R04
						d.autoinc  = wbyte[`DSR_CTL_AUTOINC];
						d.prefetch = wbyte[`DSR_CTL_PREFETCH];
					end
					`DSR_IDX_IND_OFF: begin
						d.offset = wbyte; // R01
						d.ind_rd = q.prefetch; // R06
					end
					`DSR_IDX_IND_DATA: begin
						d.wdata  = wbyte;
						d.ind_wr = 1'b1; // R02
						if (q.autoinc) begin
							d.offset = q.offset + 8'h01; // R05
						end
					end
					`DSR_IDX_BIST: begin
						d.bist_mode = wbyte[`DSR_BIST_MODE_LSB +: 2];
						d.bist_cfg  = wbyte[`DSR_BIST_CFG]; // R08
						d.bist_clk  = wbyte[`DSR_BIST_CLK_LSB +: 2];
						d.bist_en   = wbyte[`DSR_BIST_EN]; // R10
					end
					`DSR_IDX_LINK_ERR: begin
						d.err_mask  = wbyte[`DSR_ERR_MASK_BIT]; // R15
						d.err_en    = wbyte[`DSR_ERR_EN_BIT]; // R16
						d.err_limit = wbyte[`DSR_ERR_LIMIT_LSB +: 4]; // R17
					end
					default: begin
					end
				endcase
			end else if (idx == `DSR_IDX_IND_DATA && q.autoinc) begin
				d.offset = q.offset + 8'h01; // R05
				d.ind_rd = q.prefetch; // R06
			end
		end

		// self-test only runs once the config bit is cleared
		d.bist_active = q.bist_en && !q.bist_cfg; // R08 R10
		unique case (q.bist_mode[1])
			1'b1: d.pattern = DSR_PAT_DATA; // R07
			1'b0: d.pattern = q.bist_mode[0] ? DSR_PAT_ALT : DSR_PAT_NONE; // R07
		endcase
		// push the clock choice to the remote serializer on each enable
		if (d.bist_active && !q.bist_active) begin
			d.remote.wr   = 1'b1; // R09
			d.remote.data = q.bist_clk; // R09
		end
		d.remote.addr = `DSR_REMOTE_CLK_OFF;

		// straps: three stages, then one capture once stages two and three agree
		d.strap_s1 = {index_strap_pin, cfg_strap_pin};
		d.strap_s2 = q.strap_s1;
		d.strap_s3 = q.strap_s2;
		if (q.fill != `DSR_STRAP_FILL) begin
			d.fill = q.fill + 2'h1;
		end else if (!q.strap_done && q.strap_s2 == q.strap_s3) begin
			d.idx_val    = q.strap_s3[5:3]; // R12 R21
			d.cfg_val    = q.strap_s3[2:0]; // R14 R21
			d.strap_done = 1'b1; // R11 R13 R21
		end

		// lock state back from the pixel domain
		d.lock_sync = {q.lock_sync[1:0], pq.lock};
	end

	// pclk registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q             <= '0;
			q.st          <= DSR_ST_IDLE;
			q.sel         <= `DSR_RST_IND_SEL;
			q.offset      <= `DSR_RST_IND_OFF; // R01
			q.bist_cfg    <= `DSR_RST_BIST_CFG; // R08
			q.pattern     <= DSR_PAT_NONE;
			q.remote.addr <= `DSR_REMOTE_CLK_OFF;
			q.err_mask    <= `DSR_RST_ERR_MASK; // R15
			q.err_en      <= `DSR_RST_ERR_EN; // R16
			q.err_limit   <= `DSR_RST_ERR_LIMIT; // R17
		end else begin
			q <= d;
		end
	end

	// pixel domain reset: asserts at once, releases on pix_clk
	always_ff @(posedge pix_clk or negedge presetn) begin
		if (!presetn) begin
			pix_rst_q <= 2'h0;
		end else begin
			pix_rst_q <= {pix_rst_q[0], 1'b1};
		end
	end

	// link monitor; settings cross as one word through three stages and an agreement check
	logic       link_err_any;
	logic [4:0] count_next;

	assign link_err_any = |link_err; // R19

	always_comb begin
		pd         = pq;
		pd.cfg_s1  = {q.err_mask, q.err_en, q.err_limit};
		pd.cfg_s2  = pq.cfg_s1;
		pd.cfg_s3  = pq.cfg_s2;
		// take the settings word only once stages two and three agree,
		// so a write caught mid-flight never mixes old and new bits
		if (pq.cfg_s2 == pq.cfg_s3) begin
			pd.cfg_use = pq.cfg_s3;
		end
		count_next = {1'b0, pq.count} + 5'h01;
		if (lock_acquired) begin
			pd.count = 4'h0;
			pd.lock  = 1'b1;
		end else if (pq.lock && link_err_any && !(filter_wait && pq.cfg_use[5])) begin // R15
			if (!pq.cfg_use[4]) begin
				pd.lock = 1'b0; // R18
			end else if (count_next >= {1'b0, pq.cfg_use[3:0]}) begin
				pd.lock  = 1'b0; // R17
				pd.count = 4'h0;
			end else begin
				pd.count = count_next[3:0]; // R17
			end
		end
	end

	// pixel clock registers
	always_ff @(posedge pix_clk or negedge pix_rst_q[1]) begin // R20
		if (!pix_rst_q[1]) begin
			// stages start at the reset settings so no false agreement on zero
			pq         <= '0;
			pq.cfg_s1  <= {`DSR_RST_ERR_MASK, `DSR_RST_ERR_EN, `DSR_RST_ERR_LIMIT};
			pq.cfg_s2  <= {`DSR_RST_ERR_MASK, `DSR_RST_ERR_EN, `DSR_RST_ERR_LIMIT};
			pq.cfg_s3  <= {`DSR_RST_ERR_MASK, `DSR_RST_ERR_EN, `DSR_RST_ERR_LIMIT};
			pq.cfg_use <= {`DSR_RST_ERR_MASK, `DSR_RST_ERR_EN, `DSR_RST_ERR_LIMIT};
		end else begin
			pq <= pd;
		end
	end

	// outputs straight from flops
	assign prdata       = {24'h000000, q.prdata};
	assign pready       = q.pready;
	assign pslverr      = q.pslverr;
	assign ind_req      = '{target_sel: q.sel, offset: q.offset, wdata: q.wdata,
	                        wr: q.ind_wr, rd: q.ind_rd};
	assign remote_cfg   = q.remote;
	assign bist_active  = q.bist_active;
	assign bist_pattern = q.pattern;
	assign link_lock    = pq.lock;

endmodule

// ===== dsr_props.sv
// concurrent checks on the apb side, indirect outputs and remote write of the bank
// bound to dsr_shared_regs; sees its ports only, single pclk domain
`timescale 1ns/1ps
module dsr_props (
	input wire logic                  pclk,        // register clock
	input wire logic                  presetn,     // async reset, active low
	input wire logic                  psel,        // apb select
	input wire logic                  penable,     // apb access phase
	input wire logic                  pwrite,      // apb direction
	input wire logic [9:0]            paddr,       // apb byte address
	input wire logic [31:0]           pwdata,      // apb write data
	input wire logic [31:0]           prdata,      // apb read data
	input wire logic                  pready,      // apb ready
	input wire logic                  pslverr,     // apb error
	input wire dsr_pkg::dsr_ind_req_s ind_req,     // indirect request
	input wire logic [7:0]            ind_rdata,   // sub-block answer
	input wire dsr_pkg::dsr_remote_s  remote_cfg,  // remote write
	input wire logic                  bist_active  // self-test running
);
	import dsr_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// apb answer shape
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	misalign_err_a: assert property (psel && $rose(penable) && paddr[1:0] != 2'h0 |=> pready && pslverr)
		else $error("misaligned access not refused");
	byte_data_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data above the byte not zero");
	// indirect window: read passes sub-block data, write forwards the byte
	data_read_a: assert property (ind_req.rd && psel && penable && !pwrite
		|=> pready && prdata[7:0] == $past(ind_rdata))
		else $error("indirect read not from sub-block");
	data_write_a: assert property (psel && penable && pwrite && pready && paddr == 10'h2c8
		|=> ind_req.wr && ind_req.wdata == $past(pwdata[7:0]))
		else $error("indirect write not forwarded");
	wr_pulse_a: assert property (ind_req.wr |=> !ind_req.wr)
		else $error("indirect write strobe too long");
	// remote clock choice goes out exactly when self-test starts
	remote_cause_a: assert property (remote_cfg.wr |-> $rose(bist_active) && remote_cfg.addr == 8'h14)
		else $error("remote write without self-test start");
	start_remote_a: assert property ($rose(bist_active) |-> remote_cfg.wr)
		else $error("self-test start without remote write");
endmodule

bind dsr_shared_regs dsr_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .ind_req, .ind_rdata, .remote_cfg, .bist_active);

// ===== dsr_sub_model.sv
// model of the indirect sub-blocks behind the bank, one byte store per target
// answers while the read strobe stands; the bank samples at the edge that ends it
`timescale 1ns/1ps
module dsr_sub_model (
	input wire logic                  pclk,  // register clock
	input wire dsr_pkg::dsr_ind_req_s req,   // request from the bank
	output logic [7:0]                rdata  // read answer
);
	import dsr_pkg::*;
	logic [7:0] mem [8][256];
	logic [7:0] q = 8'h5a;
	// answer during a strobe, else scramble so stale data never matches
	assign rdata = req.rd ? mem[req.target_sel[2:0]][req.offset] : q;
	always @(posedge pclk) begin
		if (req.wr)
			mem[req.target_sel[2:0]][req.offset] <= req.wdata;
		q <= ~q;
	end
endmodule

// ===== dsr_shared_regs_test.sv
// bench of the shared bank: register table, indirect, self-test, lock and strap cases
// needs dsr_sub_model and the bound dsr_props
`timescale 1ns/1ps
module dsr_shared_regs_test;
	import dsr_pkg::*;
	logic          pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [9:0]    paddr = 10'h0;
	logic [31:0]   pwdata = 32'h0, prdata;
	logic          pready, pslverr, bist_active, link_lock, e;
	dsr_ind_req_s  ind_req;
	dsr_remote_s   remote_cfg;
	dsr_pattern_e  bist_pattern;
	dsr_link_err_s link_err = 4'h0;
	logic [7:0]    ind_rdata, r;
	logic [2:0]    idx_pin = 3'h5, cfg_pin = 3'h2;
	logic [1:0]    rclk = 2'h0;
	logic          pix_clk = 1'h0, filter_wait = 1'h0, lock_acq = 1'h0;
	int            failures = 0, total_checks = 0, rdn = 0, n0;
	// {wr, err, byte address, write data, expected read}
	localparam logic [27:0] rows [15] = '{28'h2c4003a, 28'h2cc0008, 28'h2c0001c,
		28'h2e40033, 28'h2d00025, 28'h2d40000, 28'h2d80018, 28'h2dc0000, 28'had0ff00,
		28'h2d00025, 28'h2e000da, 28'h7fc0000, 28'h6c5003a, 28'hac45500, 28'h2c40055};

	dsr_shared_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ind_req, .ind_rdata, .remote_cfg, .bist_active, .bist_pattern,
		.index_strap_pin(idx_pin), .cfg_strap_pin(cfg_pin), .pix_clk, .link_err,
		.filter_wait, .lock_acquired(lock_acq), .link_lock);
	dsr_sub_model sub (.pclk, .req(ind_req), .rdata(ind_rdata));

	// pixel clock period unrelated to pclk
	always #12.5 pclk = ~pclk;
	always #8.5 pix_clk = ~pix_clk;
	// strobe counter and remote capture
	always @(posedge pclk) begin
		if (ind_req.rd === 1'b1)
			rdn++;
		if (remote_cfg.wr === 1'b1)
			rclk = remote_cfg.data;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		wrap_up;
	end

	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
		total_checks++;
		if (s !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask

	task wrap_up;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// apb transfer; waits for pready under a bound, no fixed latency assumed
	task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			wrap_up;
		end
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic acq;
		@(posedge pix_clk) lock_acq <= 1'h1;
		@(posedge pix_clk) lock_acq <= 1'h0;
		repeat (3) @(posedge pix_clk);
	endtask

	task automatic pix(input int k, input logic [3:0] v);
		repeat (k) begin
			@(posedge pix_clk) link_err <= dsr_link_err_s'(v);
			@(posedge pix_clk) link_err <= 4'h0;
			repeat (3) @(posedge pix_clk);
		end
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 15; i++) begin
			apb(rows[i][27], rows[i][25:16], rows[i][15:8]);
			chk("error", {7'h0, e}, {7'h0, rows[i][26]});
			if (!rows[i][27]) chk("register", r, rows[i][7:0]);
		end
		$display("register table done");
		apb(1'h1, 10'h2c4, 8'h20);
		for (int t = 0; t < 8; t++) begin
			apb(1'h1, 10'h2c0, 8'(t << 2));
			apb(1'h1, 10'h2c8, 8'(t + 8'h40));
			apb(1'h0, 10'h2c8, 8'h00);
			chk("indirect data", r, 8'(t + 8'h40));
			chk("target", {4'h0, ind_req.target_sel}, 8'(t));
		end
		apb(1'h1, 10'h2c0, 8'h06);
		apb(1'h0, 10'h2c8, 8'h00);
		apb(1'h0, 10'h2c4, 8'h00);
		chk("offset", r, 8'h21);
		apb(1'h1, 10'h2c0, 8'h05);
		n0 = rdn;
		apb(1'h1, 10'h2c4, 8'h30);
		repeat (2) @(posedge pclk);
		chk("prefetch", 8'(rdn - n0), 8'h01);
		apb(1'h1, 10'h2c0, 8'h07);
		n0 = rdn;
		apb(1'h0, 10'h2c8, 8'h00);
		repeat (2) @(posedge pclk);
		chk("prefetch", 8'(rdn - n0), 8'h02);
		$display("indirect done");
		for (int m = 0; m < 4; m++) begin
			apb(1'h1, 10'h2cc, 8'(m << 6));
			repeat (2) @(posedge pclk);
			chk("pattern", {6'h0, bist_pattern}, m[1] ? 8'h02 : 8'(m));
		end
		apb(1'h1, 10'h2cc, 8'h45);
		repeat (3) @(posedge pclk);
		chk("active", {7'h0, bist_active}, 8'h01);
		chk("remote", {6'h0, rclk}, 8'h02);
		apb(1'h1, 10'h2cc, 8'h4d);
		repeat (2) @(posedge pclk);
		chk("active", {7'h0, bist_active}, 8'h00);
		$display("self-test done");
		acq;
		pix(2, 4'h8);
		chk("lock", {7'h0, link_lock}, 8'h01);
		apb(1'h0, 10'h300, 8'h00);
		chk("lock status", r, 8'h01);
		pix(1, 4'h8);
		chk("lock", {7'h0, link_lock}, 8'h00);
		apb(1'h0, 10'h300, 8'h00);
		chk("lock status", r, 8'h00);
		acq;
		@(posedge pix_clk) filter_wait <= 1'h1;
		pix(3, 4'h4);
		chk("lock", {7'h0, link_lock}, 8'h01);
		apb(1'h1, 10'h2e4, 8'h13);
		repeat (8) @(posedge pclk);
		pix(3, 4'h4);
		chk("lock", {7'h0, link_lock}, 8'h00);
		@(posedge pix_clk) filter_wait <= 1'h0;
		apb(1'h1, 10'h2e4, 8'h03);
		repeat (8) @(posedge pclk);
		for (int k = 0; k < 4; k++) begin
			acq;
			pix(1, 4'h8 >> k);
			chk("lock", {7'h0, link_lock}, 8'h00);
		end
		$display("lock monitor done");
		idx_pin <= 3'h3;
		cfg_pin <= 3'h6;
		repeat (10) @(posedge pclk);
		apb(1'h0, 10'h2e0, 8'h00);
		chk("strap", r, 8'hda);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("offset", ind_req.offset, 8'h3a);
		presetn <= 1'h1;
		repeat (10) @(posedge pclk);
		apb(1'h0, 10'h2e0, 8'h00);
		chk("strap", r, 8'hbe);
		$display("strap done");
		wrap_up;
	end
endmodule
